// *** dv/eeo_ctr_model.sv ***
// Far-side counting controller for the emulated encoder pins.
// Assumes pin levels that change only on clk_sys edges.
`timescale 1ns/100ps
`default_nettype none
module eeo_ctr_model (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        a_pin,
   input  wire logic        b_pin,
   input  wire logic        z_pin,
   output logic [7:0]       quad_cnt_ff,
   output logic [7:0]       a_rise_ff,
   output logic [7:0]       b_rise_ff,
   output logic [7:0]       z_rise_ff,
   output logic [15:0]      a_hi_ff
);
   logic        a_ff;
   logic        b_ff;
   logic        z_ff;
   logic [15:0] run_ff;
   // Decodes quadrature, counts rising edges and times the last high phase of A.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         {a_ff, b_ff, z_ff, run_ff, a_hi_ff} <= '0;
         {quad_cnt_ff, a_rise_ff, b_rise_ff, z_rise_ff} <= '0;
      end else begin
         a_ff <= a_pin;
         b_ff <= b_pin;
         z_ff <= z_pin;
         if ({a_pin, b_pin} != {a_ff, b_ff}) begin
            quad_cnt_ff <= (a_ff ^ b_pin) ? quad_cnt_ff + 8'h01 : quad_cnt_ff - 8'h01;
         end
         a_rise_ff <= a_rise_ff + 8'(a_pin & ~a_ff);
         b_rise_ff <= b_rise_ff + 8'(b_pin & ~b_ff);
         z_rise_ff <= z_rise_ff + 8'(z_pin & ~z_ff);
         run_ff <= a_pin ? run_ff + 16'h0001 : 16'h0000;
         if (a_ff & ~a_pin) a_hi_ff <= run_ff;
      end
   end
endmodule
`default_nettype wire

// *** dv/test_emulated_encoder_output.sv ***
// Self-checking bench for the emulated encoder output block.
// Assumes the design header and package compiled first.
`timescale 1ns/100ps
`include "eeo_defs.svh"
`default_nettype none
module test_emulated_encoder_output;
   logic              clk_sys, reset, awvalid, wvalid, arvalid, strap, pidx, ha, hb;
   logic [7:0]        awaddr, araddr, qc, ar, br, zr;
   logic [31:0]       wdata, rdata, num_errors, checks_done, cyc;
   logic [1:0]        bresp, rresp;
   logic              awready, wready, bvalid, arready, rvalid, a_o, b_o, z_o, a_oe, b_oe, z_oe;
   logic [15:0]       ahi;
   eeo_pkg::eeo_pos_s pos;
   eeo_top eeo_top_inst (.clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .prim_pos(pos),
      .analog_drive(strap), .phys_index(pidx), .eeo_a_i(ha), .eeo_a_o(a_o),
      .eeo_a_oe(a_oe), .eeo_b_i(hb), .eeo_b_o(b_o), .eeo_b_oe(b_oe), .eeo_z_o(z_o),
      .eeo_z_oe(z_oe));
   eeo_ctr_model eeo_ctr_model_inst (.clk_sys(clk_sys), .reset(reset), .a_pin(a_o),
      .b_pin(b_o), .z_pin(z_o), .quad_cnt_ff(qc), .a_rise_ff(ar), .b_rise_ff(br),
      .z_rise_ff(zr), .a_hi_ff(ahi));
   // Clock at 20 ns and a watchdog on the whole run.
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 32'h0000_4E20) begin
         num_errors = num_errors + 1;
         end_of_test();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task end_of_test();
      $display("errors=%0d checks=%0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      araddr <= a; arvalid <= 1'b1;
      do @(posedge clk_sys); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk_sys); while (rvalid !== 1'b1);
      d = rdata; r = rresp;
   endtask
   task rst(input logic s);
      @(posedge clk_sys); strap <= s; reset <= 1'b1;
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
   endtask
   task go(input logic [47:0] d, input int n);
      repeat (n) begin
         @(posedge clk_sys); pos <= eeo_pkg::eeo_pos_s'(pos + d);
      end
   endtask
   task setp(input logic [47:0] v);
      @(posedge clk_sys); pos <= v;
      repeat (4) @(posedge clk_sys);
   endtask
   // Power-up enable follows the drive-type strap; registers reset and mask; handwheel wraps.
   task t_regs();
      logic [31:0] d;
      logic [1:0]  r;
      rst(1'b1); rd(`EEO_A_STAT, d, r); chk(d & 32'h0000_0001, 32'h0000_0001);
      rst(1'b0); rd(`EEO_A_STAT, d, r); chk(d & 32'h0000_0001, 32'h0000_0000);
      rd(`EEO_A_PW, d, r); chk(d, 32'h0000_0000);
      rd(`EEO_A_RES, d, r); chk(d, 32'h0000_0000);
      wr(`EEO_A_PW, 32'hFFFF_FFFF); rd(`EEO_A_PW, d, r); chk(d, 32'h0000_0FFF);
      wr(`EEO_A_RES, 32'hFFFF_FFFF); rd(`EEO_A_RES, d, r); chk(d, 32'h00FF_FFFF);
      rd(8'h20, d, r); chk(32'(r), 32'(`EEO_RESP_DEC));
      wr(8'h22, 32'h0000_0000); chk(32'(bresp), 32'(`EEO_RESP_DEC));
      wr(`EEO_A_RES, 32'h0000_0001);
      for (int k = 0; k < 4; k++) begin
         {hb, ha} <= 2'(8'h2D >> (2 * k)); repeat (6) @(posedge clk_sys);
      end
      rd(`EEO_A_HWTURN, d, r); chk(d, 32'h0000_0001);
   endtask
   // Mode codes 0 to 14; only the output codes drive the pins.
   task t_modes();
      for (int i = 0; i < 15; i++) begin
         wr(`EEO_A_CTRL, 32'(i) | 32'h0000_0100);
         repeat (3) @(posedge clk_sys);
         chk(32'({a_oe, b_oe, z_oe}), (i inside {1, 2, 6, 7, 8, 9, 12, 13, 14}) ?
             32'h0000_0007 : 32'h0000_0000);
      end
   endtask
   // One line per rev in quadrature: four counts, unslowed by a long width, xor direction.
   task t_quad();
      logic [7:0] q0;
      wr(`EEO_A_PW, 32'h0000_0FFF); wr(`EEO_A_RES, 32'h0000_0001);
      wr(`EEO_A_CTRL, 32'h0000_0131); q0 = qc;
      go(48'h0000_0000_4000, 4); repeat (20) @(posedge clk_sys);
      chk(32'(qc - q0), 32'h0000_0004);
   endtask
   // One count of step or CW/CCW output; width and direction pin are judged.
   task t_pulse(input logic [3:0] m, input logic [11:0] pw, input logic inv,
                input logic [7:0] ea, input logic [7:0] eb);
      logic [7:0] a0, b0;
      wr(`EEO_A_PW, 32'(pw)); wr(`EEO_A_RES, 32'h0000_0001);
      wr(`EEO_A_CTRL, 32'(m) | (32'(inv) << 4) | 32'h0000_0100);
      a0 = ar; b0 = br;
      go(48'h0000_0000_4000, 4); repeat (300) @(posedge clk_sys);
      chk(32'(ar - a0), 32'(ea));
      if (m != 4'h6) chk(32'(br - b0), 32'(eb));
      else chk(32'(b_o), 32'(inv));
      if (ea != 8'h00) chk(32'(ahi), (32'(pw) * 520 + 40) / 20);
   endtask
   // Index once per rev, absolute on the chosen turn, and pass-through.
   task t_index();
      logic [7:0] z0;
      wr(`EEO_A_RES, 32'h0000_0000); wr(`EEO_A_ZOFF, 32'h0000_8000);
      wr(`EEO_A_TURN, 32'h0000_0002); wr(`EEO_A_CTRL, 32'h0000_0101); z0 = zr;
      setp(48'h0000_0000_7FFF); setp(48'h0000_0000_8000);
      chk(32'(zr - z0), 32'h0000_0001);
      wr(`EEO_A_CTRL, 32'h0000_0102); z0 = zr;
      setp(48'h0000_0001_8000); setp(48'h0000_0002_0000); setp(48'h0000_0002_8000);
      chk(32'(zr - z0), 32'h0000_0001);
      wr(`EEO_A_CTRL, 32'h0000_010C); z0 = zr;
      @(posedge clk_sys); pidx <= 1'b1;
      repeat (6) @(posedge clk_sys); pidx <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chk(32'(zr - z0), 32'h0000_0001);
   endtask
   // Main sequence.
   initial begin
      reset = 1'b1; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0; strap = 1'b0;
      pidx = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000; pos = '0;
      ha = 1'b0; hb = 1'b0;
      num_errors = 32'h0000_0000; checks_done = 32'h0000_0000; cyc = 32'h0000_0000;
      t_regs();
      t_modes();
      t_quad();
      t_pulse(4'h6, 12'h001, 1'b1, 8'h01, 8'h00);
      t_pulse(4'h8, 12'h003, 1'b0, 8'h01, 8'h00);
      t_pulse(4'h9, 12'h002, 1'b1, 8'h00, 8'h01);
      t_index();
      end_of_test();
   end
endmodule
`default_nettype wire

// *** hdl/eeo_defs.svh ***
// Register map, field positions and timing constants of the emulated encoder output.
// Assumes a 50 MHz system clock; include by bare name.
`ifndef EEO_DEFS_SVH
`define EEO_DEFS_SVH
`define EEO_A_CTRL      8'h00
`define EEO_A_RES       8'h04
`define EEO_A_ZOFF      8'h08
`define EEO_A_TURN      8'h0C
`define EEO_A_PW        8'h10
`define EEO_A_STAT      8'h14
`define EEO_A_HWCNT     8'h18
`define EEO_A_HWTURN    8'h1C
`define EEO_B_DIRINV    4
`define EEO_B_DRVDIR    5
`define EEO_B_EN        8
`define EEO_PW_W        12
`define EEO_RES_W       24
`define EEO_RESP_OK     2'h0
`define EEO_RESP_DEC    2'h3
`define EEO_REV_ONE     48'h0000_0001_0000
`define EEO_CLK_NS      20
`define EEO_PW_STEP_NS  520
`define EEO_PW_FIX_NS   40
`define EEO_PW_DEF_NS   4080
`define EEO_PW_STEP_CYC (`EEO_PW_STEP_NS / `EEO_CLK_NS)
`define EEO_PW_FIX_CYC  (`EEO_PW_FIX_NS / `EEO_CLK_NS)
`define EEO_PW_DEF_CNT  ((`EEO_PW_DEF_NS - `EEO_PW_FIX_NS + `EEO_PW_STEP_NS - 1) / `EEO_PW_STEP_NS)
`define EEO_EDGES_LINE  4
`endif

// *** hdl/eeo_pkg.sv ***
// Types shared by the emulated encoder output block.
// Assumes nothing of its surroundings.
package eeo_pkg;
   typedef enum logic [1:0] {EEO_F_NONE, EEO_F_AB, EEO_F_STEP, EEO_F_CW} eeo_fmt_e;
   typedef enum logic [1:0] {EEO_Z_NONE, EEO_Z_REV, EEO_Z_ABS, EEO_Z_PASS} eeo_zk_e;
   typedef struct packed {
      logic [31:0] turn;
      logic [15:0] frac;
   } eeo_pos_s;
   typedef struct packed {
      logic [3:0]  mode;
      logic        dir_inv;
      logic        drive_direction_select;
      logic        en;
      logic [23:0] res;
      logic [15:0] zoff;
      logic [31:0] turn;
      logic [11:0] pw;
   } eeo_cfg_s;
endpackage

// *** hdl/eeo_top.sv ***
// Emulated encoder output: turns primary position into A/B, step/dir or CW/CCW pulses.
// Assumes an AXI4-Lite master on clk_sys and a position source on the same clock.
//
// Functional notes
// R1: Absolute index modes 2, 7, 9 put the index on the selected turn.
// R2: Absolute index angle inside that turn comes from the index position setting.
// R3: Pulse width setting affects step and CW/CCW modes only, not quadrature.
// R4: Pulse width is a 12-bit read/write field, bits 15:12 reserved, reset zero.
// R5: Pulse lasts count times 520 ns plus 40 ns.
// R6: Count one is the minimum and gives 560 ns; software programs no less.
// R7: Software computes count as (width minus 40 ns) divided by 520 ns.
// R8: Resolution means lines per rev in modes 1-3, counts per rev in 4-5.
// R9: Resolution accepts 0 to 16777215 and resets to zero.
// R10: Output emits resolution lines per rev; input counts them as one handwheel rev.
// R11: Mode 1 emits index when in-rev position equals index position setting.
// R12: Step pulse width spans 4.08 us to 2621.48 us, default 4.08 us; code gives 0.56 us to 2129.44 us, default 4.2 us.
// R13: Software enable gates the axis; power-up value set by analog drive type.
// R14: Modes 1/6/8 once per rev, 2/7/9 absolute, 12-14 index pass-through.
// R15: Output direction is drive direction xor output direction invert.
// R16: Absolute index fires when full position equals turn and in-rev offset.
// R17: Reserved pulse width bits read zero and do not affect pulses.
`timescale 1ns/100ps
`include "eeo_defs.svh"
`default_nettype none
module eeo_top #(
   parameter int unsigned PW_STEP_CYC = `EEO_PW_STEP_CYC,
   parameter int unsigned PW_FIX_CYC  = `EEO_PW_FIX_CYC
) (
   input  wire logic            clk_sys,
   input  wire logic            reset,
   input  wire logic [7:0]      s_axi_awaddr,
   input  wire logic            s_axi_awvalid,
   output logic                 s_axi_awready,
   input  wire logic [31:0]     s_axi_wdata,
   input  wire logic [3:0]      s_axi_wstrb,
   input  wire logic            s_axi_wvalid,
   output logic                 s_axi_wready,
   output logic [1:0]           s_axi_bresp,
   output logic                 s_axi_bvalid,
   input  wire logic            s_axi_bready,
   input  wire logic [7:0]      s_axi_araddr,
   input  wire logic            s_axi_arvalid,
   output logic                 s_axi_arready,
   output logic [31:0]          s_axi_rdata,
   output logic [1:0]           s_axi_rresp,
   output logic                 s_axi_rvalid,
   input  wire logic            s_axi_rready,
   input  wire eeo_pkg::eeo_pos_s prim_pos,
   input  wire logic            analog_drive,
   input  wire logic            phys_index,
   input  wire logic            eeo_a_i,
   output logic                 eeo_a_o,
   output logic                 eeo_a_oe,
   input  wire logic            eeo_b_i,
   output logic                 eeo_b_o,
   output logic                 eeo_b_oe,
   output logic                 eeo_z_o,
   output logic                 eeo_z_oe
);
   // -----------------------------------------------------------------
   // Mode decoding
   // -----------------------------------------------------------------
   // Output format of a mode value.
   function automatic eeo_pkg::eeo_fmt_e fmt_of(input logic [3:0] m);
      case (m)
         4'h1, 4'h2, 4'hC: fmt_of = eeo_pkg::EEO_F_AB; // R14
         4'h6, 4'h7, 4'hD: fmt_of = eeo_pkg::EEO_F_STEP; // R14
         4'h8, 4'h9, 4'hE: fmt_of = eeo_pkg::EEO_F_CW; // R14
         default: fmt_of = eeo_pkg::EEO_F_NONE;
      endcase
   endfunction
   // Index kind of a mode value.
   function automatic eeo_pkg::eeo_zk_e zk_of(input logic [3:0] m);
      case (m)
         4'h1, 4'h6, 4'h8: zk_of = eeo_pkg::EEO_Z_REV; // R14
         4'h2, 4'h7, 4'h9: zk_of = eeo_pkg::EEO_Z_ABS; // R1
         4'hC, 4'hD, 4'hE: zk_of = eeo_pkg::EEO_Z_PASS; // R14
         default: zk_of = eeo_pkg::EEO_Z_NONE;
      endcase
   endfunction

   eeo_pkg::eeo_cfg_s cfg_ff;
   eeo_pkg::eeo_fmt_e fmt;
   eeo_pkg::eeo_zk_e  zk;
   logic              out_on;
   logic              dir;
   assign fmt    = fmt_of(cfg_ff.mode);
   assign zk     = zk_of(cfg_ff.mode);
   assign out_on = (fmt != eeo_pkg::EEO_F_NONE);
   assign dir    = cfg_ff.drive_direction_select ^ cfg_ff.dir_inv; // R15

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   logic [3:0] s1_ff;
   logic [3:0] s2_ff;
   // Two flops for every level arriving from outside the clock domain.
   always_ff @(posedge clk_sys) begin
      s1_ff <= {analog_drive, phys_index, eeo_b_i, eeo_a_i};
      s2_ff <= s1_ff;
   end

   // -----------------------------------------------------------------
   // AXI4-Lite slave
   // -----------------------------------------------------------------
   logic [7:0]  aw_ff;
   logic        awh_ff;
   logic [31:0] wd_ff;
   logic [3:0]  ws_ff;
   logic        wh_ff;
   logic        do_wr;
   assign s_axi_awready = !awh_ff;
   assign s_axi_wready  = !wh_ff;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_wr = awh_ff && wh_ff && !s_axi_bvalid;
   // Address and data are caught in either order; the write fires once both are held.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         awh_ff <= 1'b0;
         wh_ff  <= 1'b0;
         aw_ff  <= 8'h00;
         wd_ff  <= 32'h0000_0000;
         ws_ff  <= 4'h0;
      end else begin
         if (s_axi_awvalid && !awh_ff) begin
            awh_ff <= 1'b1;
            aw_ff  <= s_axi_awaddr;
         end else if (do_wr) begin
            awh_ff <= 1'b0;
         end
         if (s_axi_wvalid && !wh_ff) begin
            wh_ff <= 1'b1;
            wd_ff <= s_axi_wdata;
            ws_ff <= s_axi_wstrb;
         end else if (do_wr) begin
            wh_ff <= 1'b0;
         end
      end
   end

   // Address is mapped when it names one of the word registers.
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= `EEO_A_HWTURN);
   endfunction

   // Write response follows the committed write.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `EEO_RESP_OK;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(aw_ff) ? `EEO_RESP_OK : `EEO_RESP_DEC;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Byte-lane merge of a write onto an old register word.
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         merge[8*i +: 8] = s[i] ? d[8*i +: 8] : o[8*i +: 8];
      end
   endfunction

   logic        en_load_ff;
   logic [31:0] ctrl_w;
   assign ctrl_w = merge({23'h00_0000, cfg_ff.en, 2'h0, cfg_ff.drive_direction_select, cfg_ff.dir_inv,
                          cfg_ff.mode}, wd_ff, ws_ff);
   // Configuration registers; the enable takes its power-up value after reset.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cfg_ff     <= '0; // R9 R4
         en_load_ff <= 1'b1;
      end else begin
         en_load_ff <= 1'b0;
         if (en_load_ff) begin
            cfg_ff.en <= s2_ff[3]; // R13
         end
         if (do_wr) begin
            case (aw_ff)
               `EEO_A_CTRL: begin
                  cfg_ff.mode    <= ctrl_w[3:0];
                  cfg_ff.dir_inv <= ctrl_w[`EEO_B_DIRINV];
                  cfg_ff.drive_direction_select <= ctrl_w[`EEO_B_DRVDIR];
                  cfg_ff.en      <= ctrl_w[`EEO_B_EN]; // R13
               end
               `EEO_A_RES: cfg_ff.res <= 24'(merge({8'h00, cfg_ff.res}, wd_ff,
                                                   ws_ff)); // R9
               `EEO_A_ZOFF: cfg_ff.zoff <= 16'(merge({16'h0000, cfg_ff.zoff}, wd_ff,
                                                     ws_ff));
               `EEO_A_TURN: cfg_ff.turn <= merge(cfg_ff.turn, wd_ff, ws_ff);
               `EEO_A_PW: cfg_ff.pw <= 12'(merge({20'h0_0000, cfg_ff.pw}, wd_ff,
                                                 ws_ff)); // R4 R17
               default: ;
            endcase
         end
      end
   end

   logic [23:0] hw_cnt_ff;
   logic [31:0] hw_turn_ff;
   logic        busy;
   logic [31:0] rd_word;
   // Read data mux; reserved bits read zero.
   always_comb begin
      case (s_axi_araddr)
         `EEO_A_CTRL: rd_word = {23'h00_0000, cfg_ff.en, 2'h0, cfg_ff.drive_direction_select,
                                 cfg_ff.dir_inv, cfg_ff.mode};
         `EEO_A_RES: rd_word = {8'h00, cfg_ff.res};
         `EEO_A_ZOFF: rd_word = {16'h0000, cfg_ff.zoff};
         `EEO_A_TURN: rd_word = cfg_ff.turn;
         `EEO_A_PW: rd_word = {20'h0_0000, cfg_ff.pw}; // R17
         `EEO_A_STAT: rd_word = {29'h0000_0000, busy, out_on, cfg_ff.en};
         `EEO_A_HWCNT: rd_word = {8'h00, hw_cnt_ff};
         `EEO_A_HWTURN: rd_word = hw_turn_ff;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   logic rd_pw_ff;
   // Read answer one cycle after the address is taken.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `EEO_RESP_OK;
         rd_pw_ff     <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= mapped(s_axi_araddr) ? `EEO_RESP_OK : `EEO_RESP_DEC;
         rd_pw_ff     <= (s_axi_araddr == `EEO_A_PW);
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Position to count rate
   // -----------------------------------------------------------------
   logic [15:0]        frac_ff;
   logic [15:0]        fdiff;
   logic signed [16:0] delta;
   logic [25:0]        mult;
   logic signed [47:0] acc_ff;
   logic signed [47:0] sum;
   logic               up;
   logic               dn;
   logic               take;
   // Frame step, signed by its own top bit and negated when the output runs reversed.
   assign fdiff = prim_pos.frac - frac_ff;
   assign delta = $signed({fdiff[15], fdiff}) * (dir ? -17'sd1 : 17'sd1); // R15
   // Quadrature makes four counts per line, step modes one count per line.
   assign mult = (fmt == eeo_pkg::EEO_F_AB) ? {cfg_ff.res, 2'h0} : {2'h0, cfg_ff.res}; // R8 R10
   assign sum  = acc_ff + 48'($signed({1'b0, mult}) * delta);
   assign up   = acc_ff >= $signed(`EEO_REV_ONE);
   assign dn   = acc_ff <= -$signed(`EEO_REV_ONE);
   assign take = (up || dn) && !busy && cfg_ff.en && out_on; // R13
   // Fractional count accumulator; one count leaves per taken step.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         frac_ff <= 16'h0000;
         acc_ff  <= '0;
      end else begin
         frac_ff <= prim_pos.frac;
         if (!cfg_ff.en || !out_on) begin
            acc_ff <= '0;
         end else if (take) begin
            acc_ff <= up ? sum - $signed(`EEO_REV_ONE) : sum + $signed(`EEO_REV_ONE);
         end else begin
            acc_ff <= sum;
         end
      end
   end

   // -----------------------------------------------------------------
   // Pulse engine
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW} eeo_st_e;
   eeo_st_e     st_ff;
   logic [17:0] tcnt_ff;
   logic [17:0] len_ff;
   logic [17:0] len;
   logic [11:0] pw_eff;
   logic        sdir_ff;
   logic [1:0]  quad_ff;
   // A zero count means unprogrammed and runs at the default width.
   assign pw_eff = (cfg_ff.pw == 12'h000) ? 12'(`EEO_PW_DEF_CNT) : cfg_ff.pw; // R12 R6
   assign len = 18'(pw_eff * PW_STEP_CYC + PW_FIX_CYC); // R5
   assign busy = (st_ff != ST_IDLE);
   // Step modes hold a timed high phase and an equal low gap; quadrature steps at once.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_ff   <= ST_IDLE;
         tcnt_ff <= '0;
         len_ff  <= '0;
         sdir_ff <= 1'b0;
         quad_ff <= 2'h0;
      end else begin
         case (st_ff)
            ST_IDLE: begin
               if (take && fmt == eeo_pkg::EEO_F_AB) begin
                  quad_ff <= up ? quad_ff + 2'h1 : quad_ff - 2'h1; // R3
               end else if (take) begin
                  st_ff   <= ST_HIGH;
                  tcnt_ff <= len - 18'h1; // R5
                  len_ff  <= len;
                  sdir_ff <= dn;
               end
            end
            ST_HIGH: begin
               tcnt_ff <= tcnt_ff - 18'h1;
               if (tcnt_ff == '0) begin
                  st_ff   <= ST_LOW;
                  tcnt_ff <= len_ff - 18'h1;
               end
            end
            ST_LOW: begin
               tcnt_ff <= tcnt_ff - 18'h1;
               if (tcnt_ff == '0) st_ff <= ST_IDLE;
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Index and pin drive
   // -----------------------------------------------------------------
   logic z_hit;
   // Index position match by mode kind.
   always_comb begin
      case (zk)
         eeo_pkg::EEO_Z_REV: z_hit = (prim_pos.frac == cfg_ff.zoff); // R11
         eeo_pkg::EEO_Z_ABS: z_hit = (prim_pos.turn == cfg_ff.turn) && // R1 R16
                                     (prim_pos.frac == cfg_ff.zoff); // R2
         eeo_pkg::EEO_Z_PASS: z_hit = s2_ff[2];
         default: z_hit = 1'b0;
      endcase
   end

   logic hi;
   assign hi = (st_ff == ST_HIGH);
   // Registered pin drive; pins float as inputs outside output modes.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         {eeo_a_o, eeo_b_o, eeo_z_o} <= 3'h0;
         {eeo_a_oe, eeo_b_oe, eeo_z_oe} <= 3'h0;
      end else begin
         {eeo_a_oe, eeo_b_oe, eeo_z_oe} <= {3{out_on}}; // R10
         eeo_z_o <= z_hit && cfg_ff.en;
         case (fmt)
            eeo_pkg::EEO_F_AB: {eeo_a_o, eeo_b_o} <= {quad_ff[1], ^quad_ff}; // R3
            eeo_pkg::EEO_F_STEP: {eeo_a_o, eeo_b_o} <= {hi, sdir_ff};
            eeo_pkg::EEO_F_CW: {eeo_a_o, eeo_b_o} <= {hi && !sdir_ff, hi && sdir_ff};
            default: {eeo_a_o, eeo_b_o} <= 2'h0;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Handwheel input
   // -----------------------------------------------------------------
   logic [1:0]  hab_ff;
   logic [25:0] edges;
   logic        hup;
   logic        hdn;
   assign edges = {cfg_ff.res, 2'h0};
   assign hup = (hab_ff == 2'b00 && s2_ff[1:0] == 2'b01) ||
                (hab_ff == 2'b01 && s2_ff[1:0] == 2'b11) ||
                (hab_ff == 2'b11 && s2_ff[1:0] == 2'b10) ||
                (hab_ff == 2'b10 && s2_ff[1:0] == 2'b00);
   assign hdn = (hab_ff != s2_ff[1:0]) && !hup && (hab_ff[0] ^ hab_ff[1] ^ s2_ff[0] ^ s2_ff[1]);
   // Quadrature edges counted; four edges per line and res lines make one turn.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         hab_ff     <= 2'h0;
         hw_cnt_ff  <= '0;
         hw_turn_ff <= '0;
      end else begin
         hab_ff <= s2_ff[1:0];
         if (!out_on && cfg_ff.res != '0) begin
            if (hup && 26'(hw_cnt_ff) + 26'h1 >= edges) begin
               hw_cnt_ff  <= '0; // R10
               hw_turn_ff <= hw_turn_ff + 32'h1;
            end else if (hup) begin
               hw_cnt_ff <= hw_cnt_ff + 24'h1;
            end else if (hdn && hw_cnt_ff == '0) begin
               hw_cnt_ff  <= 24'(edges - 26'h1);
               hw_turn_ff <= hw_turn_ff - 32'h1;
            end else if (hdn) begin
               hw_cnt_ff <= hw_cnt_ff - 24'h1;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   logic [17:0] hcnt_ff;
   // Helper: cycles spent in the high phase of the current pulse.
   always_ff @(posedge clk_sys) begin
      if (reset || !hi) hcnt_ff <= '0;
      else hcnt_ff <= hcnt_ff + 18'h1;
   end
   pulse_len_a: assert property (@(posedge clk_sys) disable iff (reset) // R5
      (hi && tcnt_ff == '0) |-> (hcnt_ff + 18'h1 == len_ff)) else $error("pulse length off");
   pw_latch_a: assert property (@(posedge clk_sys) disable iff (reset) // R6
      (take && fmt == eeo_pkg::EEO_F_STEP && cfg_ff.pw == 12'h001) |=>
      (len_ff == 18'(PW_STEP_CYC + PW_FIX_CYC))) else $error("count one width wrong");
   pw_default_a: assert property (@(posedge clk_sys) disable iff (reset) // R12
      (cfg_ff.pw == 12'h000) |-> (pw_eff == 12'(`EEO_PW_DEF_CNT)))
      else $error("default width wrong");
   quad_gray_a: assert property (@(posedge clk_sys) disable iff (reset) // R3
      (fmt == eeo_pkg::EEO_F_AB && $stable(fmt)) |=> !($changed(eeo_a_o) && $changed(eeo_b_o)))
      else $error("quadrature double edge");
   pw_resv_a: assert property (@(posedge clk_sys) disable iff (reset) // R17
      (s_axi_rvalid && rd_pw_ff) |-> (s_axi_rdata[31:12] == 20'h0_0000))
      else $error("reserved bits set");
   z_rev_a: assert property (@(posedge clk_sys) disable iff (reset) // R11
      (zk == eeo_pkg::EEO_Z_REV && cfg_ff.en && prim_pos.frac == cfg_ff.zoff && !do_wr)
      |=> eeo_z_o) else $error("index missed");
   z_abs_a: assert property (@(posedge clk_sys) disable iff (reset) // R16
      (eeo_z_o && $past(zk) == eeo_pkg::EEO_Z_ABS) |->
      ($past(prim_pos.turn) == $past(cfg_ff.turn) && $past(prim_pos.frac) == $past(cfg_ff.zoff)))
      else $error("absolute index misplaced");
   en_gate_a: assert property (@(posedge clk_sys) disable iff (reset) // R13
      (!cfg_ff.en && !busy) |=> (!busy && $stable(quad_ff))) else $error("step while disabled");
   dir_xor_a: assert property (@(posedge clk_sys) disable iff (reset) // R15
      (fdiff != 16'h0000 && !fdiff[15]) |-> (delta[16] == (cfg_ff.drive_direction_select ^ cfg_ff.dir_inv)))
      else $error("output direction wrong");
   hw_wrap_a: assert property (@(posedge clk_sys) disable iff (reset) // R10
      (!out_on && cfg_ff.res != '0 && $stable(cfg_ff.res)) |-> (26'(hw_cnt_ff) < edges))
      else $error("handwheel count past turn");
endmodule
`default_nettype wire
